// ==== rtl/sil_core.sv ====
// serial peripheral control, flags, interrupts, pins and shifters
`timescale 1ns/10ps
// Contract
// - fault flag never sets without detect enable
// - received byte sets receive-full, gated interrupt
// - byte into shifter sets transmit-empty, gated interrupt
// - master starts queued byte right after previous
// - slave resends shifter value when nothing queued
// - system reset clears the system-clock side; link-clock registers keep their values
// - disabled: empty set, abort, clear shifter, pins
// - disable keeps control bits and flags other than transmit-empty, which it sets
// - master mode fault disables the module
// - wait keeps running, interrupts wake processor
// - no register access during wait
// - stop halts activity, keeps registers
// - reset out of stop aborts transfer
// - break with clear enable allows flag clearing
// - break without clear enable blocks flag clearing; flags still set
// - data write ignored in protected break
// - wired-or mode makes master data out (mosi) open drain; slave miso stays push-pull
// - master shifts out and in together
// - slave drives data out only when selected
// - enabled module owns data pin directions
// - error enable gates overrun and fault
// - receive interrupt also needs module enable
module sil_core (
  // system clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // link clock from the remote master
  input wire logic serial_clock_i,
  // processor access strobes and data
  input wire logic wr_ctrl_i,
  input wire sil_pkg::sil_ctrl_t ctrl_i,
  input wire logic wr_stat_ctrl_i,
  input wire sil_pkg::sil_stat_ctrl_t stat_ctrl_i,
  input wire logic wr_data_i,
  input wire logic [7:0] data_i,
  input wire logic rd_status_i,
  input wire logic rd_data_i,
  // system state
  input wire logic wait_i,
  input wire logic stop_i,
  input wire logic break_i,
  input wire logic break_clear_enable_i,
  // pins in
  input wire logic slave_select_n_i,
  input wire logic miso_i,
  input wire logic mosi_i,
  // readback
  output sil_pkg::sil_ctrl_t ctrl_o,
  output sil_pkg::sil_stat_ctrl_t stat_ctrl_o,
  output sil_pkg::sil_flags_t flags_o,
  output logic [7:0] rx_data_o,
  // interrupt requests and wake
  output logic rx_err_irq_o,
  output logic tx_irq_o,
  output logic wake_o,
  // pins out
  output logic port_owned_o,
  output logic sclk_o,
  output logic sclk_oe_o,
  output logic mosi_o,
  output logic mosi_oe_o,
  output logic miso_o,
  output logic miso_oe_o
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  sil_pkg::sil_ctrl_t ctrl; // control bits
  sil_pkg::sil_stat_ctrl_t stat; // status control bits
  sil_pkg::sil_flags_t flags; // status flags
  logic [7:0] rx_data; // receive data register
  logic [7:0] tx_hold; // transmit data register
  logic arm_rx; // first step of receive clear done
  logic arm_ov; // first step of overrun clear done
  logic arm_mf; // first step of fault clear done
  logic tx_req; // toggles when slave byte is queued
  sil_pkg::sil_state_t m_state; // master shifter state
  logic [4:0] m_div; // half period counter
  logic [2:0] m_cnt; // master bit counter
  logic [7:0] m_sh; // master shift register
  logic m_bit; // sampled input bit
  logic ss_s1, ss_s2, miso_s1, miso_s2; // pin synchronisers
  logic ack_s1, ack_s2, ack_seen; // slave load acknowledge
  logic done_s1, done_s2, done_seen; // slave byte done

  // link domain; no edges outside frames, so start values matter
  logic ack_l = 1'b0;
  logic done_l = 1'b0;
  logic [2:0] l_cnt = 3'h0;
  logic [7:0] l_sh = 8'h00;
  logic [7:0] l_rx = 8'h00;

  // ----------------------------------------------------------------
  // decoded conditions
  // ----------------------------------------------------------------
  logic access; // processor may reach the registers
  logic clr_ok; // flags may change from accesses
  logic en;
  logic m_load; // master moves held byte to shifter
  logic m_last; // master finishes its eighth bit
  logic fault; // master sees select driven low
  logic rx_evt; // a byte arrives from either shifter
  logic [7:0] rx_byte;
  logic [4:0] half;
  logic l_pend; // slave byte waiting at frame start
  logic [7:0] l_in; // slave shifter source

  assign access = !wait_i;
  assign clr_ok = !break_i || break_clear_enable_i;
  assign en = ctrl.module_enable;
  assign fault = en && ctrl.master_select &&
                 stat.fault_detect_enable && !ss_s2;
  assign m_load = en && ctrl.master_select && !stop_i &&
                  !flags.tx_empty_flag &&
                  (m_state == sil_pkg::SIL_IDLE || m_last);
  assign m_last = m_state == sil_pkg::SIL_HIGH && m_div == half &&
                  m_cnt == sil_pkg::SIL_LAST_BIT && !stop_i;
  assign rx_evt = m_last || (done_s2 != done_seen);
  assign rx_byte = m_last ? {m_sh[6:0], m_bit} : l_rx;

  // baud code picks the half period
  always_comb begin
    case ({stat.baud_select_hi, stat.baud_select_lo})
      2'h0: half = sil_pkg::SIL_HALF_0;
      2'h1: half = sil_pkg::SIL_HALF_1;
      2'h2: half = sil_pkg::SIL_HALF_2;
      default: half = sil_pkg::SIL_HALF_3;
    endcase
  end

  // ----------------------------------------------------------------
  // pin and handshake synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    ss_s1 <= slave_select_n_i;
    ss_s2 <= ss_s1;
    miso_s1 <= miso_i;
    miso_s2 <= miso_s1;
    ack_s1 <= ack_l;
    ack_s2 <= ack_s1;
    done_s1 <= done_l;
    done_s2 <= done_s1;
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // only system reset clears these, save a mode fault clearing module_enable; disable leaves them alone
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ctrl <= sil_pkg::SIL_CTRL_RST;
    end else if (fault) begin
      ctrl.module_enable <= 1'b0;
    end else if (wr_ctrl_i && access) begin
      ctrl <= ctrl_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      stat <= sil_pkg::SIL_STAT_RST;
    end else if (wr_stat_ctrl_i && access) begin
      stat <= stat_ctrl_i;
    end
  end

  // ----------------------------------------------------------------
  // transmit data register and queue toggle
  // ----------------------------------------------------------------
  // a write while not empty still overwrites; software must wait
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      tx_hold <= sil_pkg::SIL_BYTE_RST;
      tx_req <= 1'b0;
    end else if (!en) begin
      tx_req <= ack_s2; // drop any slave byte still queued
    end else if (wr_data_i && access && clr_ok) begin
      tx_hold <= data_i;
      if (!ctrl.master_select) begin
        tx_req <= ~ack_s2;
      end
    end
  end

  // ----------------------------------------------------------------
  // status flags, set wins over clear
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      flags <= sil_pkg::SIL_FLAGS_RST;
      rx_data <= sil_pkg::SIL_BYTE_RST;
      // adopt the link toggles so reset raises no stale event
      ack_seen <= ack_s2;
      done_seen <= done_s2;
    end else begin
      ack_seen <= ack_s2;
      done_seen <= done_s2;
      // transmit-empty
      if (!en || m_load || ack_s2 != ack_seen) begin
        flags.tx_empty_flag <= 1'b1;
      end else if (wr_data_i && access && clr_ok) begin
        flags.tx_empty_flag <= 1'b0;
      end
      // receive-full and overrun
      if (rx_evt && flags.rx_full_flag) begin
        flags.overrun_flag <= 1'b1; // old byte kept
      end else if (rx_evt) begin
        flags.rx_full_flag <= 1'b1;
        rx_data <= rx_byte;
      end
      if (rd_data_i && access && clr_ok) begin
        if (arm_rx && !rx_evt) begin
          flags.rx_full_flag <= 1'b0;
        end
        if (arm_ov && !(rx_evt && flags.rx_full_flag)) begin
          flags.overrun_flag <= 1'b0;
        end
      end
      // mode fault, cleared by status read then control write
      if (fault) begin
        flags.mode_fault_flag <= 1'b1;
      end else if (wr_ctrl_i && access && clr_ok && arm_mf) begin
        flags.mode_fault_flag <= 1'b0;
      end
    end
  end

  // first step of each two-step clear; frozen in a protected break
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      arm_rx <= 1'b0;
      arm_ov <= 1'b0;
      arm_mf <= 1'b0;
    end else if (access && clr_ok) begin
      if (rd_status_i) begin
        arm_rx <= flags.rx_full_flag;
        arm_ov <= flags.overrun_flag;
        arm_mf <= flags.mode_fault_flag && !fault;
      end else begin
        if (rd_data_i) begin
          arm_rx <= 1'b0;
          arm_ov <= 1'b0;
        end
        if (wr_ctrl_i || fault) begin
          arm_mf <= 1'b0; // a live fault spoils the sequence
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // master shifter
  // ----------------------------------------------------------------
  // stop freezes the shifter in place so it resumes where it was
  always_ff @(posedge mclk_i) begin
    if (reset_i || !en || !ctrl.master_select) begin
      m_state <= sil_pkg::SIL_IDLE;
      m_sh <= sil_pkg::SIL_BYTE_RST;
      m_cnt <= 3'h0;
      m_div <= 5'h01;
      m_bit <= 1'b0;
    end else if (!stop_i) begin
      case (m_state)
        sil_pkg::SIL_IDLE: begin
          if (m_load) begin
            m_sh <= tx_hold;
            m_cnt <= 3'h0;
            m_div <= 5'h01;
            m_state <= sil_pkg::SIL_LOW;
          end
        end
        sil_pkg::SIL_LOW: begin
          if (m_div == half) begin
            m_div <= 5'h01;
            m_bit <= miso_s2;
            m_state <= sil_pkg::SIL_HIGH;
          end else begin
            m_div <= m_div + 5'h01;
          end
        end
        sil_pkg::SIL_HIGH: begin
          if (m_div != half) begin
            m_div <= m_div + 5'h01;
          end else if (m_load) begin
            m_sh <= tx_hold;
            m_cnt <= 3'h0;
            m_div <= 5'h01;
            m_state <= sil_pkg::SIL_LOW;
          end else if (m_last) begin
            m_sh <= {m_sh[6:0], m_bit};
            m_state <= sil_pkg::SIL_IDLE;
          end else begin
            m_sh <= {m_sh[6:0], m_bit};
            m_cnt <= m_cnt + 3'h1;
            m_div <= 5'h01;
            m_state <= sil_pkg::SIL_LOW;
          end
        end
        default: m_state <= sil_pkg::SIL_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // slave shifter on the link clock
  // ----------------------------------------------------------------
  // mode bits and queue toggle are read straight: the link clock stands
  // still between frames, so a synchroniser on it could not pass them
  // before the first bit; they are quasi-static, as software sets the
  // mode and queues its byte before select goes low
  // queued byte enters only at a frame start
  assign l_pend = l_cnt == 3'h0 && tx_req != ack_l;
  assign l_in = l_pend ? tx_hold : l_sh;

  always_ff @(posedge serial_clock_i) begin
    if (!en || ctrl.master_select) begin
      l_cnt <= 3'h0;
      l_sh <= sil_pkg::SIL_BYTE_RST;
    end else if (!stop_i && !slave_select_n_i) begin
      l_sh <= {l_in[6:0], mosi_i};
      l_cnt <= l_cnt + 3'h1;
      if (l_pend) begin
        ack_l <= ~ack_l;
      end
      if (l_cnt == sil_pkg::SIL_LAST_BIT) begin
        l_rx <= {l_sh[6:0], mosi_i};
        done_l <= ~done_l;
      end
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  assign port_owned_o = en;
  assign sclk_o = m_state == sil_pkg::SIL_HIGH;
  assign sclk_oe_o = en && ctrl.master_select;
  // open drain drives only the low level
  assign mosi_o = ctrl.wired_or_mode ? 1'b0 : m_sh[7];
  assign mosi_oe_o = en && ctrl.master_select &&
                     (!ctrl.wired_or_mode || !m_sh[7]);
  assign miso_o = l_in[7];
  assign miso_oe_o = en && !ctrl.master_select &&
                     !slave_select_n_i;

  // ----------------------------------------------------------------
  // readback and interrupt requests
  // ----------------------------------------------------------------
  assign ctrl_o = ctrl;
  assign stat_ctrl_o = stat;
  assign flags_o = flags;
  assign rx_data_o = rx_data;
  assign rx_err_irq_o = (flags.rx_full_flag && ctrl.rx_irq_enable &&
                        en) || (stat.error_irq_enable &&
                        (flags.overrun_flag ||
                        flags.mode_fault_flag));
  assign tx_irq_o = flags.tx_empty_flag && ctrl.tx_irq_enable;
  assign wake_o = rx_err_irq_o || tx_irq_o;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_fault_needs_en;
    @(posedge mclk_i) disable iff (reset_i)
    $rose(flags.mode_fault_flag) |-> $past(stat.fault_detect_enable);
  endproperty
  a_fault_needs_en: assert property (p_fault_needs_en)
    else $error("fault flag set without detect enable");

  property p_rx_full;
    @(posedge mclk_i) disable iff (reset_i)
    rx_evt && !flags.rx_full_flag |=>
      flags.rx_full_flag && rx_data == $past(rx_byte);
  endproperty
  a_rx_full: assert property (p_rx_full)
    else $error("received byte not stored");

  property p_tx_empty;
    @(posedge mclk_i) disable iff (reset_i)
    m_load |=> flags.tx_empty_flag && m_sh == $past(tx_hold);
  endproperty
  a_tx_empty: assert property (p_tx_empty)
    else $error("transmit-empty not set on load");

  property p_back_to_back;
    @(posedge mclk_i) disable iff (reset_i)
    m_last && m_load |=> m_state == sil_pkg::SIL_LOW && m_cnt == 3'h0;
  endproperty
  a_back_to_back: assert property (p_back_to_back)
    else $error("queued byte did not follow at once");

  property p_disable;
    @(posedge mclk_i) disable iff (reset_i)
    !en |-> !port_owned_o ##1 (flags.tx_empty_flag &&
            m_state == sil_pkg::SIL_IDLE && m_sh == sil_pkg::SIL_BYTE_RST);
  endproperty
  a_disable: assert property (p_disable)
    else $error("disable did not clear transfer state");

  property p_keep_ctrl;
    @(posedge mclk_i) disable iff (reset_i)
    $fell(en) |-> $stable(stat) && $stable(flags.rx_full_flag);
  endproperty
  a_keep_ctrl: assert property (p_keep_ctrl)
    else $error("disable changed control bits");

  property p_fault_off;
    @(posedge mclk_i) disable iff (reset_i)
    fault |=> !en && flags.mode_fault_flag ##1 !sclk_oe_o;
  endproperty
  a_fault_off: assert property (p_fault_off)
    else $error("master fault did not disable");

  property p_wait_block;
    @(posedge mclk_i) disable iff (reset_i)
    wait_i && (wr_data_i || wr_stat_ctrl_i) |=>
      $stable(tx_hold) && $stable(stat);
  endproperty
  a_wait_block: assert property (p_wait_block)
    else $error("register written during wait");

  property p_break_write;
    @(posedge mclk_i) disable iff (reset_i)
    break_i && !break_clear_enable_i && wr_data_i && !m_load |=>
      $stable(tx_hold) && $stable(tx_req);
  endproperty
  a_break_write: assert property (p_break_write)
    else $error("data write took effect in break");

  property p_miso_drive;
    @(posedge mclk_i) disable iff (reset_i)
    miso_oe_o |-> !ctrl.master_select && !slave_select_n_i && en;
  endproperty
  a_miso_drive: assert property (p_miso_drive)
    else $error("data out driven while unselected");

  c_master_byte: cover property (@(posedge mclk_i) disable iff (reset_i)
    m_last && m_load);
  c_slave_byte: cover property (@(posedge mclk_i) disable iff (reset_i)
    done_s2 != done_seen);
  c_overrun: cover property (@(posedge mclk_i) disable iff (reset_i)
    $rose(flags.overrun_flag));
  c_fault: cover property (@(posedge mclk_i) disable iff (reset_i)
    fault);

endmodule

// ==== rtl/sil_pkg.sv ====
// shared constants and carriers for the serial peripheral control block
package sil_pkg;

  // ----------------------------------------------------------------
  // control register carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rx_irq_enable;
    logic master_select;
    logic wired_or_mode;
    logic module_enable;
    logic tx_irq_enable;
  } sil_ctrl_t;

  typedef struct packed {
    logic error_irq_enable;
    logic fault_detect_enable;
    logic baud_select_hi;
    logic baud_select_lo;
  } sil_stat_ctrl_t;

  // status flags
  typedef struct packed {
    logic rx_full_flag;
    logic overrun_flag;
    logic mode_fault_flag;
    logic tx_empty_flag;
  } sil_flags_t;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam sil_ctrl_t SIL_CTRL_RST = 5'h08; // master_select set
  localparam sil_stat_ctrl_t SIL_STAT_RST = 4'h0;
  localparam sil_flags_t SIL_FLAGS_RST = 4'h1; // tx_empty set
  localparam logic [7:0] SIL_BYTE_RST = 8'h00;

  // ----------------------------------------------------------------
  // timing: half serial clock period in system clocks per baud code
  // ----------------------------------------------------------------
  localparam logic [4:0] SIL_HALF_0 = 5'h01;
  localparam logic [4:0] SIL_HALF_1 = 5'h04;
  localparam logic [4:0] SIL_HALF_2 = 5'h08;
  localparam logic [4:0] SIL_HALF_3 = 5'h10;
  localparam logic [2:0] SIL_LAST_BIT = 3'h7;

  // master shifter states, gray along idle -> low -> high
  typedef enum logic [1:0] {
    SIL_IDLE = 2'h0,
    SIL_LOW = 2'h1,
    SIL_HIGH = 2'h3
  } sil_state_t;

endpackage

// ==== bench/sil_remote.sv ====
// remote serial party: slave to the block as master, master to it as slave
`timescale 1ns/10ps
module sil_remote (
  // lines from the block
  input wire logic sclk_i,
  input wire logic sclk_oe_i,
  input wire logic mosi_line_i,
  input wire logic miso_line_i,
  // lines toward the block
  output logic serial_clock_o,
  output logic mosi_o,
  output logic miso_o
);
  // ---------------------------------------------------------------
  // remote slave: fixed answer byte, msb first
  // ---------------------------------------------------------------
  localparam logic [7:0] REPLY = 8'h5A; // answer byte
  logic [7:0] shreg = REPLY; // outgoing bits
  logic [7:0] got = 8'h00; // last bits heard from the block
  logic [2:0] nbits = 3'h0; // falls seen in this byte
  assign miso_o = shreg[7];
  // capture on the rise, in step with our own output
  always @(posedge sclk_i) got <= {got[6:0], mosi_line_i};
  // advance on the fall; resync when the block drops the clock
  always @(negedge sclk_i or negedge sclk_oe_i) begin
    if (!sclk_oe_i || nbits == 3'h7) begin
      nbits <= 3'h0;
      shreg <= REPLY;
    end else begin
      nbits <= nbits + 3'h1;
      shreg <= {shreg[6:0], ~shreg[7]};
    end
  end
  // ---------------------------------------------------------------
  // remote master: 160 ns clock, still between frames
  // ---------------------------------------------------------------
  initial begin
    serial_clock_o = 1'b0;
    mosi_o = 1'b1;
  end
  // data set and answer taken before the rise; both sides shift on it
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi_o = tx[i];
      #80 rx[i] = miso_line_i;
      serial_clock_o = 1'b1;
      #80 serial_clock_o = 1'b0;
    end
    #80 mosi_o = ~tx[0]; // released line must not keep its level
  endtask
endmodule

// ==== bench/sil_core_tb_top.sv ====
// self-checking bench for the serial peripheral control block
`timescale 1ns/10ps
module sil_core_tb_top;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam int WC = 0, WS = 1, WD = 2, RS = 3, RD = 4; // access kinds
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic wr_ctrl_i, wr_stat_ctrl_i, wr_data_i, rd_status_i, rd_data_i;
  logic wait_i, stop_i, break_i, break_clear_enable_i, slave_select_n_i;
  logic serial_clock_i, miso_i, mosi_i, mosi_line, miso_line, seen_clk;
  logic [7:0] data_i, rx_data_o, r;
  sil_pkg::sil_ctrl_t ctrl_i, ctrl_o;
  sil_pkg::sil_stat_ctrl_t stat_ctrl_i, stat_ctrl_o;
  sil_pkg::sil_flags_t flags_o;
  logic rx_err_irq_o, tx_irq_o, wake_o, port_owned_o, sclk_o, sclk_oe_o;
  logic mosi_o, mosi_oe_o, miso_o, miso_oe_o;
  int bad_count = 0;
  int num_checks = 0;
  always #25 mclk_i = ~mclk_i;
  // pull-up on the data-out line, miso floats when released
  assign mosi_line = mosi_oe_o ? mosi_o : 1'b1;
  assign miso_line = miso_oe_o ? miso_o : 1'bz;
  sil_core u_dut (
    .mclk_i(mclk_i), .reset_i(reset_i), .serial_clock_i(serial_clock_i),
    .wr_ctrl_i(wr_ctrl_i), .ctrl_i(ctrl_i), .wr_stat_ctrl_i(wr_stat_ctrl_i),
    .stat_ctrl_i(stat_ctrl_i), .wr_data_i(wr_data_i), .data_i(data_i),
    .rd_status_i(rd_status_i), .rd_data_i(rd_data_i), .wait_i(wait_i),
    .stop_i(stop_i), .break_i(break_i),
    .break_clear_enable_i(break_clear_enable_i),
    .slave_select_n_i(slave_select_n_i), .miso_i(miso_i), .mosi_i(mosi_i),
    .ctrl_o(ctrl_o), .stat_ctrl_o(stat_ctrl_o), .flags_o(flags_o),
    .rx_data_o(rx_data_o), .rx_err_irq_o(rx_err_irq_o),
    .tx_irq_o(tx_irq_o), .wake_o(wake_o), .port_owned_o(port_owned_o),
    .sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o), .mosi_o(mosi_o),
    .mosi_oe_o(mosi_oe_o), .miso_o(miso_o), .miso_oe_o(miso_oe_o));
  sil_remote u_remote (
    .sclk_i(sclk_o), .sclk_oe_i(sclk_oe_o), .mosi_line_i(mosi_line),
    .miso_line_i(miso_line), .serial_clock_o(serial_clock_i),
    .mosi_o(mosi_i), .miso_o(miso_i));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  // inputs move 1 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one strobe cycle of the given kind; only that strobe moves
  task automatic acc(input int k, input logic [7:0] v);
    ctrl_i = v[4:0];
    stat_ctrl_i = v[3:0];
    data_i = v;
    case (k)
      WC: wr_ctrl_i = 1'b1;
      WS: wr_stat_ctrl_i = 1'b1;
      WD: wr_data_i = 1'b1;
      RS: rd_status_i = 1'b1;
      default: rd_data_i = 1'b1;
    endcase
    tick(1);
    case (k)
      WC: wr_ctrl_i = 1'b0;
      WS: wr_stat_ctrl_i = 1'b0;
      WD: wr_data_i = 1'b0;
      RS: rd_status_i = 1'b0;
      default: rd_data_i = 1'b0;
    endcase
  endtask
  // bounded waits on the two flags
  task automatic wait_rx(input int n);
    for (int i = 0; i < n && flags_o.rx_full_flag !== 1'b1; i++) tick(1);
  endtask
  task automatic wait_tx(input int n);
    for (int i = 0; i < n && flags_o.tx_empty_flag !== 1'b1; i++) tick(1);
  endtask
  task automatic chk_rst();
    check(ctrl_o, sil_pkg::SIL_CTRL_RST);
    check(stat_ctrl_o, sil_pkg::SIL_STAT_RST);
    check(flags_o, sil_pkg::SIL_FLAGS_RST);
    check(rx_data_o, sil_pkg::SIL_BYTE_RST);
    check({rx_err_irq_o, port_owned_o, mosi_oe_o}, 8'h00);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // watchdog: tests need under 6000 cycles
  // ---------------------------------------------------------------
  initial begin
    #1000000;
    bad_count++;
    wrap_up();
  end
  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    {wr_ctrl_i, wr_stat_ctrl_i, wr_data_i, rd_status_i, rd_data_i} = 5'h00;
    {wait_i, stop_i, break_i, break_clear_enable_i} = 4'h0;
    slave_select_n_i = 1'b1;
    ctrl_i = 5'h00;
    stat_ctrl_i = 4'h0;
    data_i = 8'h00;
    tick(5);
    reset_i = 1'b0;
    chk_rst();
    $display("reset test done");
    // master, slowest baud, back to back
    acc(WS, 8'h03);
    acc(WC, 8'h1B);
    check({port_owned_o, miso_oe_o, tx_irq_o}, 8'h05);
    acc(WD, 8'hA5);
    wait_tx(20);
    acc(WD, 8'h3C);
    wait_rx(600);
    check(rx_data_o, 8'h5A);
    check({rx_err_irq_o, u_remote.got}, 9'h1A5);
    acc(RS, 8'h00);
    acc(RD, 8'h00);
    check(flags_o.rx_full_flag, 8'h00);
    wait_rx(262);
    check({flags_o.rx_full_flag, u_remote.got}, 9'h13C);
    acc(RS, 8'h00);
    acc(RD, 8'h00);
    $display("master test done");
    // stop freezes the link, then resumes
    acc(WD, 8'h0F);
    tick(40);
    stop_i = 1'b1;
    seen_clk = sclk_o;
    tick(100);
    check({sclk_o, flags_o.rx_full_flag}, {seen_clk, 1'b0});
    stop_i = 1'b0;
    wait_rx(600);
    check(u_remote.got, 8'h0F);
    // disable mid-transfer keeps control bits and flags other than transmit-empty
    acc(WD, 8'h77);
    tick(60);
    acc(WC, 8'h19);
    tick(2);
    check({flags_o, port_owned_o, sclk_oe_o}, 8'h24);
    check({ctrl_o, stat_ctrl_o}, 9'h193);
    check(rx_err_irq_o, 8'h00);
    tick(300);
    check(rx_data_o, 8'h5A);
    $display("stop and disable tests done");
    // break without clear enable
    acc(RS, 8'h00);
    break_i = 1'b1;
    acc(RD, 8'h00);
    check(flags_o.rx_full_flag, 8'h01);
    acc(WC, 8'h1B);
    acc(WD, 8'h11);
    tick(2);
    check({flags_o.tx_empty_flag, sclk_o}, 8'h02);
    break_i = 1'b0;
    acc(RD, 8'h00);
    check(flags_o.rx_full_flag, 8'h00);
    // break with clear enable
    acc(WD, 8'h22);
    wait_rx(600);
    break_i = 1'b1;
    break_clear_enable_i = 1'b1;
    acc(RS, 8'h00);
    acc(RD, 8'h00);
    break_i = 1'b0;
    tick(2);
    check(flags_o.rx_full_flag, 8'h00);
    break_clear_enable_i = 1'b0;
    $display("break test done");
    // wait mode: link runs, strobes ignored, wake raised
    acc(WD, 8'h44);
    wait_i = 1'b1;
    wait_rx(600);
    check({wake_o, u_remote.got}, 9'h144);
    acc(WC, 8'h00);
    acc(WS, 8'h00);
    acc(RS, 8'h00);
    acc(RD, 8'h00);
    check({ctrl_o, flags_o.rx_full_flag}, 8'h37);
    check(stat_ctrl_o, 8'h03);
    wait_i = 1'b0;
    acc(RS, 8'h00);
    acc(RD, 8'h00);
    $display("wait test done");
    // mode fault: blocked without detect enable, then disables
    slave_select_n_i = 1'b0;
    tick(6);
    check({flags_o.mode_fault_flag, ctrl_o.module_enable}, 8'h01);
    acc(WS, 8'h0F);
    tick(6);
    check({flags_o.mode_fault_flag, ctrl_o, rx_err_irq_o}, 7'h73);
    check(port_owned_o, 8'h00);
    slave_select_n_i = 1'b1;
    tick(4);
    acc(RS, 8'h00);
    acc(WC, 8'h13);
    check({flags_o.mode_fault_flag, miso_oe_o}, 8'h00);
    $display("fault test done");
    // slave: select gates miso, stale shifter resent
    acc(WD, 8'hC3);
    slave_select_n_i = 1'b0;
    tick(3);
    check(miso_oe_o, 8'h01);
    u_remote.xfer(8'h96, r);
    check(r, 8'hC3);
    tick(1);
    wait_rx(20);
    check(rx_data_o, 8'h96);
    acc(RS, 8'h00);
    acc(RD, 8'h00);
    u_remote.xfer(8'h69, r);
    check(r, 8'h96);
    slave_select_n_i = 1'b1;
    tick(3);
    check(miso_oe_o, 8'h00);
    $display("slave test done");
    // wired-or master: ones leave the line released
    acc(WC, 8'h1F);
    acc(WD, 8'hFF);
    tick(8);
    check({mosi_oe_o, port_owned_o}, 8'h01);
    // reset out of stop aborts the transfer
    wait_tx(20);
    acc(WD, 8'h55);
    tick(40);
    stop_i = 1'b1;
    reset_i = 1'b1;
    tick(2);
    reset_i = 1'b0;
    stop_i = 1'b0;
    chk_rst();
    tick(300);
    check(flags_o.rx_full_flag, 8'h00);
    $display("stop reset test done");
    wrap_up();
  end
endmodule
